// ==== common/pixel_defines.svh ====
// Purpose: constants shared by both ends of the pixel chain link
// Assumes: system clock of 50 MHz
// Notes: times are kept in their own units, cycle counts derived
`ifndef PIXEL_DEFINES_SVH
`define PIXEL_DEFINES_SVH

`define SYS_CLK_HZ 50_000_000
`define SYS_CLK_NS 20
// Frame layout
`define MARK_BITS 6'd32
`define WORD_LAST 5'd31
`define FLAG_MSB 31
`define FLAG_LSB 29
`define DIM_MSB 28
`define DIM_LSB 24
`define BLUE_MSB 23
`define BLUE_LSB 16
`define GREEN_MSB 15
`define GREEN_LSB 8
`define RED_MSB 7
`define RED_LSB 0
`define FLAG_START 3'h7
`define SLEEP_CODE 8'hA0
`define COLOURS_OFF 24'h00_0000
// Reset values of display state
`define DIM_RST 5'h00
`define LEVEL_RST 8'h00
// Wake-up time, 1 ms, least time rounded up
`define WAKE_TIME_US 1000
`define WAKE_CYCLES ((`WAKE_TIME_US * 1000 + `SYS_CLK_NS - 1) / `SYS_CLK_NS)
// PWM repetition rate, 256 steps per period, step rounded down
`define PWM_RATE_HZ 20_000
`define PWM_STEPS 256
`define PWM_STEP_CYCLES (`SYS_CLK_HZ / (`PWM_RATE_HZ * `PWM_STEPS))
// Host link clock half period
`define LINK_HALF_NS 80
`define LINK_HALF_CYCLES (`LINK_HALF_NS / `SYS_CLK_NS)

`endif

// ==== common/pixel_pkg.sv ====
// Purpose: types shared by both ends of the pixel chain link
// Assumes: nothing
// Notes: one-hot state codes
package pixel_pkg;
	typedef logic [7:0] level_t;
	typedef logic [4:0] dim_t;
	typedef logic [31:0] word_t;

	typedef enum logic [1:0] {
		DEV_FWD = 2'b01,
		DEV_TAKE = 2'b10
	} dev_state_e;

	typedef enum logic [4:0] {
		HOST_IDLE = 5'b00001,
		HOST_MARK = 5'b00010,
		HOST_LOAD = 5'b00100,
		HOST_SEND = 5'b01000,
		HOST_TAIL = 5'b10000
	} host_state_e;
endpackage

// ==== common/pixel_link_if.sv ====
// Purpose: two-wire link, clock plus data, from upstream to a pixel
// Assumes: upstream drives both wires
// Notes: no clocking block
`timescale 1ns/1ps
`default_nettype none
interface pixel_link_if;
	logic link_clock;
	logic link_data;

	modport host (
		output link_clock,
		output link_data
	);
	modport dev (
		input link_clock,
		input link_data
	);
endinterface
`default_nettype wire

// ==== hdl/pixel_device.sv ====
// Purpose: serial front end and drive control of one chained RGB pixel
// Assumes: link clock sampled by clk_sys, at least 3 cycles per level
// Notes: link_clock_in arrives on up.link_clock
//
// Summary of operation
// - 32 zeros on data mark frame start
// - Next 32 bits after marker are ours
// - Word MSB first: flag, dim, B, G, R
// - Data sampled on incoming clock rising edge
// - Outgoing clock is incoming clock inverted
// - Clock and data out are regenerated
// - First one after marker opens the word
// - Flag 111 latches dimming and colours
// - Bits after our word are forwarded
// - Host adds N/2 trailing clocks, rounded up
// - Dimming picks one of 32 currents
// - Colour byte sets 256-level PWM duty
// - PWM repeats at about 20 kHz
// - PWM runs on from latched values
// - Byte A0 with black enters sleep
// - Sleep stops oscillator and PWM
// - Non-A0 word wakes sleeping pixel
// - Woken circuitry ready within 1 ms
// - Host waits 1 ms after wake; pixel_host has no such wait
// - Repeated sleep word keeps sleep state
// - Sleeping pixel still forwards stream
`timescale 1ns/1ps
`include "pixel_defines.svh"
`default_nettype none
module pixel_device #(
	parameter int unsigned WAKE_CYCLES = `WAKE_CYCLES
) (
	// System
	input wire logic clk_sys,
	input wire logic rst_b,
	// Upstream link
	pixel_link_if.dev up,
	// Downstream link
	output logic link_clock_out,
	output logic link_data_out,
	// Drivers
	output pixel_pkg::dim_t dim_level,
	output logic pwm_red,
	output logic pwm_green,
	output logic pwm_blue,
	// Status
	output logic sleeping,
	output logic osc_ready
);
	import pixel_pkg::*;

	logic clk_meta_r;
	logic clk_sync_r;
	logic clk_prev_r;
	logic dat_meta_r;
	logic dat_sync_r;
	logic [5:0] zero_cnt_r;
	dev_state_e state_r;
	logic [4:0] bit_cnt_r;
	word_t shift_r;
	logic link_clock_out_r;
	logic dout_r;
	dim_t dim_r;
	level_t blue_r;
	level_t green_r;
	level_t red_r;
	logic sleep_r;
	logic [19:0] wake_cnt_r;
	logic [3:0] pre_cnt_r;
	logic [7:0] pwm_cnt_r;

	// Link decode
	wire link_rise;
	wire bit_in;
	wire marker_seen;
	wire start_take;
	wire word_done;
	wire word_t word_full;
	wire [2:0] flag_f;
	wire [4:0] dim_f;
	wire [23:0] colours_f;
	wire is_display;
	wire is_sleep_cmd;
	wire wake_cmd;
	wire dout_nxt;

	assign link_rise = clk_sync_r & ~clk_prev_r;
	assign bit_in = dat_sync_r;
	assign marker_seen = zero_cnt_r == `MARK_BITS;
	assign start_take = link_rise & bit_in & marker_seen &
		(state_r == DEV_FWD);
	assign word_done = link_rise & (state_r == DEV_TAKE) &
		(bit_cnt_r == `WORD_LAST);
	assign word_full = {shift_r[30:0], bit_in};
	assign flag_f = word_full[`FLAG_MSB:`FLAG_LSB];
	assign dim_f = word_full[`DIM_MSB:`DIM_LSB];
	assign colours_f = word_full[`BLUE_MSB:`RED_LSB];
	assign is_display = flag_f == `FLAG_START;
	assign is_sleep_cmd = ({flag_f, dim_f} == `SLEEP_CODE) &
		(colours_f == `COLOURS_OFF);
	assign wake_cmd = sleep_r & ({flag_f, dim_f} != `SLEEP_CODE);
	// Own word replaced by zeros, the rest forwarded
	assign dout_nxt = (start_take | (state_r == DEV_TAKE)) ?
		1'b0 : bit_in;

	// Input synchronisers
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			clk_meta_r <= 1'b0;
			clk_sync_r <= 1'b0;
			clk_prev_r <= 1'b0;
			dat_meta_r <= 1'b0;
			dat_sync_r <= 1'b0;
		end else begin
			clk_meta_r <= up.link_clock;
			clk_sync_r <= clk_meta_r;
			clk_prev_r <= clk_sync_r;
			dat_meta_r <= up.link_data;
			dat_sync_r <= dat_meta_r;
		end
	end

	// Zero run counter, saturates at the marker length
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			zero_cnt_r <= 6'd0;
		end else if (link_rise) begin
			if (bit_in) begin
				zero_cnt_r <= 6'd0;
			end else if (!marker_seen) begin
				zero_cnt_r <= zero_cnt_r + 6'd1;
			end
		end
	end

	// Word capture
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= DEV_FWD;
			bit_cnt_r <= 5'd0;
			shift_r <= 32'h0000_0000;
		end else if (start_take) begin
			state_r <= DEV_TAKE;
			bit_cnt_r <= 5'd1;
			shift_r <= {31'h0000_0000, bit_in};
		end else if (word_done) begin
			state_r <= DEV_FWD;
			bit_cnt_r <= 5'd0;
		end else if (link_rise && state_r == DEV_TAKE) begin
			bit_cnt_r <= bit_cnt_r + 5'd1;
			shift_r <= word_full;
		end
	end

	// Regenerated outputs, data moves on the incoming rising edge
	// so the next pixel samples it half a cycle later
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			link_clock_out_r <= 1'b1;
			dout_r <= 1'b0;
		end else begin
			link_clock_out_r <= ~clk_sync_r;
			if (link_rise) begin
				dout_r <= dout_nxt;
			end
		end
	end

	// Display registers
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			dim_r <= `DIM_RST;
			blue_r <= `LEVEL_RST;
			green_r <= `LEVEL_RST;
			red_r <= `LEVEL_RST;
		end else if (word_done && is_display) begin
			dim_r <= dim_f;
			blue_r <= word_full[`BLUE_MSB:`BLUE_LSB];
			green_r <= word_full[`GREEN_MSB:`GREEN_LSB];
			red_r <= word_full[`RED_MSB:`RED_LSB];
		end
	end

	// Sleep state and wake-up delay
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			sleep_r <= 1'b0;
			wake_cnt_r <= 20'h0_0000;
		end else if (word_done && is_sleep_cmd) begin
			// A repeated sleep word leaves everything as it is
			sleep_r <= 1'b1;
			wake_cnt_r <= 20'h0_0000;
		end else if (word_done && wake_cmd) begin
			sleep_r <= 1'b0;
			wake_cnt_r <= WAKE_CYCLES[19:0];
		end else if (wake_cnt_r != 20'h0_0000) begin
			wake_cnt_r <= wake_cnt_r - 20'h0_0001;
		end
	end

	// PWM timebase, cleared while the oscillator is stopped
	wire osc_on;
	wire pwm_step;
	assign osc_on = ~sleep_r & (wake_cnt_r == 20'h0_0000);
	assign pwm_step = pre_cnt_r == 4'(`PWM_STEP_CYCLES - 1);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pre_cnt_r <= 4'h0;
			pwm_cnt_r <= 8'h00;
		end else if (!osc_on) begin
			pre_cnt_r <= 4'h0;
			pwm_cnt_r <= 8'h00;
		end else if (pwm_step) begin
			pre_cnt_r <= 4'h0;
			pwm_cnt_r <= pwm_cnt_r + 8'h01;
		end else begin
			pre_cnt_r <= pre_cnt_r + 4'h1;
		end
	end

	// Drivers, compare registered so outputs come from flip-flops
	logic red_q;
	logic green_q;
	logic blue_q;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			red_q <= 1'b0;
			green_q <= 1'b0;
			blue_q <= 1'b0;
		end else begin
			red_q <= osc_on & (pwm_cnt_r < red_r);
			green_q <= osc_on & (pwm_cnt_r < green_r);
			blue_q <= osc_on & (pwm_cnt_r < blue_r);
		end
	end

	assign link_clock_out = link_clock_out_r;
	assign link_data_out = dout_r;
	assign dim_level = dim_r;
	assign pwm_red = red_q;
	assign pwm_green = green_q;
	assign pwm_blue = blue_q;
	assign sleeping = sleep_r;
	assign osc_ready = osc_on;
endmodule
`default_nettype wire

// ==== hdl/pixel_host.sv ====
// Purpose: upstream controller driving a chain of pixels
// Assumes: user supplies one 32-bit word per pixel on request
// Notes: link clock is divided from clk_sys and stops between words
`timescale 1ns/1ps
`include "pixel_defines.svh"
`default_nettype none
module pixel_host (
	// System
	input wire logic clk_sys,
	input wire logic rst_b,
	// Link to first pixel
	pixel_link_if.host dn,
	// Frame control
	input wire logic frame_go,
	input wire logic [7:0] pixel_count,
	output logic busy,
	// Word supply
	input wire logic word_valid,
	output logic word_ready,
	input wire pixel_pkg::word_t word_data
);
	import pixel_pkg::*;

	host_state_e state_r;
	logic [1:0] div_r;
	logic lclk_r;
	logic ldat_r;
	word_t shift_r;
	logic [4:0] bit_cnt_r;
	logic [7:0] pix_left_r;
	logic [7:0] tail_left_r;

	wire running;
	wire tick;
	wire fall;
	wire last_bit;
	wire load_take;
	wire go_take;
	wire [8:0] tail_sum;

	assign running = (state_r == HOST_MARK) | (state_r == HOST_SEND) |
		(state_r == HOST_TAIL);
	assign tick = running & (div_r == 2'(`LINK_HALF_CYCLES - 1));
	assign fall = tick & lclk_r;
	assign last_bit = bit_cnt_r == `WORD_LAST;
	assign load_take = (state_r == HOST_LOAD) & word_valid;
	assign go_take = (state_r == HOST_IDLE) & frame_go &
		(pixel_count != 8'h00);
	assign tail_sum = {1'b0, pixel_count} + 9'h001;
	assign word_ready = state_r == HOST_LOAD;
	assign busy = state_r != HOST_IDLE;

	// Clock divider
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			div_r <= 2'd0;
			lclk_r <= 1'b0;
		end else if (!running) begin
			div_r <= 2'd0;
			lclk_r <= 1'b0;
		end else if (tick) begin
			div_r <= 2'd0;
			lclk_r <= ~lclk_r;
		end else begin
			div_r <= div_r + 2'd1;
		end
	end

	// Sequencer, data changes on falling link edges
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= HOST_IDLE;
			ldat_r <= 1'b0;
			shift_r <= 32'h0000_0000;
			bit_cnt_r <= 5'd0;
			pix_left_r <= 8'h00;
			tail_left_r <= 8'h00;
		end else if (go_take) begin
			state_r <= HOST_MARK;
			ldat_r <= 1'b0;
			bit_cnt_r <= 5'd0;
			pix_left_r <= pixel_count;
			tail_left_r <= tail_sum[8:1];
		end else if (load_take) begin
			state_r <= HOST_SEND;
			shift_r <= word_data;
			ldat_r <= word_data[31];
			bit_cnt_r <= 5'd0;
		end else if (fall) begin
			unique case (state_r)
				HOST_MARK: begin
					bit_cnt_r <= bit_cnt_r + 5'd1;
					if (last_bit) begin
						state_r <= HOST_LOAD;
					end
				end
				HOST_SEND: begin
					bit_cnt_r <= bit_cnt_r + 5'd1;
					shift_r <= {shift_r[30:0], 1'b0};
					ldat_r <= shift_r[30];
					if (last_bit) begin
						pix_left_r <= pix_left_r - 8'h01;
						ldat_r <= 1'b0;
						state_r <= (pix_left_r == 8'h01) ?
							HOST_TAIL : HOST_LOAD;
					end
				end
				HOST_TAIL: begin
					tail_left_r <= tail_left_r - 8'h01;
					if (tail_left_r == 8'h01) begin
						state_r <= HOST_IDLE;
					end
				end
				HOST_IDLE, HOST_LOAD: begin
				end
			endcase
		end
	end

	assign dn.link_clock = lclk_r;
	assign dn.link_data = ldat_r;
endmodule
`default_nettype wire

// ==== tb/pixel_link_chk.sv ====
// Purpose: concurrent checks on the host link and first pixel
// Assumes: one clk_sys domain, WAKE_CYCLES of 20
// Notes: instantiated beside the link interface
`timescale 1ns/1ps
`default_nettype none
module pixel_link_chk (
	// System
	input wire logic clk_sys,
	input wire logic rst_b,
	// Host and link
	input wire logic link_clock,
	input wire logic link_data,
	input wire logic busy,
	input wire logic frame_go,
	input wire logic [7:0] pixel_count,
	input wire logic word_ready,
	// First pixel
	input wire logic link_clock_out,
	input wire logic sleeping,
	input wire logic osc_ready,
	input wire logic pwm_red
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	chk_clock_inverted: assert property (
		$rose(link_clock) |-> ##[2:4] $fell(link_clock_out))
		else $error("clock out not inverted");
	chk_idle_low: assert property (
		!busy |-> !link_clock)
		else $error("link clock runs while idle");
	chk_data_on_fall: assert property (
		$changed(link_data) |-> !link_clock)
		else $error("data moved with clock high");
	chk_ready_busy: assert property (
		word_ready |-> busy && !link_clock)
		else $error("word request outside frame");
	chk_go_busy: assert property (
		frame_go && !busy && pixel_count != 8'h00 |=> busy)
		else $error("frame not started");
	chk_sleep_dark: assert property (
		sleeping |=> !pwm_red)
		else $error("pwm on while asleep");
	chk_sleep_osc: assert property (
		sleeping |-> !osc_ready)
		else $error("oscillator ready while asleep");
	chk_wake_time: assert property (
		$fell(sleeping) |-> !osc_ready [*8] ##[1:40] osc_ready)
		else $error("wake time wrong");
	cover property ($rose(sleeping));
	cover property ($fell(sleeping));
	cover property ($rose(word_ready));
endmodule
`default_nettype wire

// ==== tb/rgb_pixel_chain_receiver_tb_top.sv ====
// Purpose: host feeding a chain of two pixels, end to end
// Assumes: wake delay cut to 20 cycles
// Notes: driver queues expected state, watcher compares
`timescale 1ns/1ps
`default_nettype none
module rgb_pixel_chain_receiver_tb_top;
	import pixel_pkg::*;
	logic clk_sys, rst_b, frame_go, word_valid, busy, word_ready;
	logic clk_a, dat_a, slp_a, rdy_a, pr_a, slp_b;
	logic pg_a, pb_a;
	logic [7:0] pixel_count;
	word_t word_data, a, b;
	dim_t dim_a, dim_b;
	int failures = 0;
	int tests_run = 0;
	int cyc = 0;
	int cnt;
	int cnt_g;
	int cnt_b;
	logic [11:0] exp_q[$];
	pixel_link_if lk0();
	pixel_link_if lk1();
	assign lk1.link_clock = clk_a;
	assign lk1.link_data = dat_a;
	pixel_host u_pixel_host (.clk_sys(clk_sys), .rst_b(rst_b), .dn(lk0),
		.frame_go(frame_go), .pixel_count(pixel_count), .busy(busy),
		.word_valid(word_valid), .word_ready(word_ready),
		.word_data(word_data));
	pixel_device #(.WAKE_CYCLES(20)) u_pixel_device (.clk_sys(clk_sys),
		.rst_b(rst_b), .up(lk0), .link_clock_out(clk_a),
		.link_data_out(dat_a), .dim_level(dim_a), .pwm_red(pr_a),
		.pwm_green(pg_a), .pwm_blue(pb_a), .sleeping(slp_a),
		.osc_ready(rdy_a));
	pixel_device #(.WAKE_CYCLES(20)) u_pixel_device_2 (.clk_sys(clk_sys),
		.rst_b(rst_b), .up(lk1), .link_clock_out(), .link_data_out(),
		.dim_level(dim_b), .pwm_red(), .pwm_green(), .pwm_blue(),
		.sleeping(slp_b), .osc_ready());
	pixel_link_chk u_pixel_link_chk (.clk_sys(clk_sys), .rst_b(rst_b),
		.link_clock(lk0.link_clock), .link_data(lk0.link_data),
		.busy(busy), .frame_go(frame_go), .pixel_count(pixel_count),
		.word_ready(word_ready), .link_clock_out(clk_a),
		.sleeping(slp_a), .osc_ready(rdy_a), .pwm_red(pr_a));

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		tests_run++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// One frame of two words, then settle
	task automatic frame(input word_t w0, input word_t w1,
			input logic [11:0] e, input string name);
		exp_q.push_back(e);
		@(posedge clk_sys) #1 frame_go = 1;
		@(posedge clk_sys) #1 frame_go = 0;
		word_data = w0;
		word_valid = 1;
		for (int i = 0; i < 2; i++) begin
			do @(negedge clk_sys); while (word_ready !== 1'b1);
			@(posedge clk_sys) #1 word_data = w1;
		end
		word_valid = 0;
		do @(negedge clk_sys); while (busy !== 1'b0);
		repeat (60) @(negedge clk_sys);
		$display("test %s done", name);
	endtask

	initial begin
		clk_sys = 0;
		forever #10 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			failures++;
			close_out();
		end
	end

	initial begin
		wait (rst_b === 1'b1);
		forever begin
			@(negedge busy);
			repeat (30) @(negedge clk_sys);
			chk({slp_a, dim_a, slp_b, dim_b}, exp_q.pop_front());
		end
	end

	initial begin
		rst_b = 0;
		frame_go = 0;
		word_valid = 0;
		pixel_count = 8'h02;
		word_data = 32'h0000_0000;
		void'($urandom(32'h3d6c_7a3d));
		repeat (12) @(posedge clk_sys);
		#1 rst_b = 1;
		a = {3'h7, 29'($urandom)};
		b = {3'h7, 29'($urandom)};
		frame(a, b, {1'b0, a[28:24], 1'b0, b[28:24]}, "update");
		b = {3'h7, 29'($urandom)};
		frame(32'hA000_0000, b, {1'b1, a[28:24], 1'b0, b[28:24]}, "sleep");
		b = {3'h7, 29'($urandom)};
		frame(32'hA000_0000, b, {1'b1, a[28:24], 1'b0, b[28:24]}, "stay");
		a = {3'h7, 29'($urandom)};
		frame(a, 32'hA000_0000, {1'b0, a[28:24], 1'b1, b[28:24]}, "wake");
		// No further link traffic while the woken pixel settles
		repeat (20) @(negedge clk_sys);
		cnt = 0;
		cnt_g = 0;
		cnt_b = 0;
		repeat (2304) begin
			@(negedge clk_sys);
			cnt += (pr_a === 1'b1);
			cnt_g += (pg_a === 1'b1);
			cnt_b += (pb_a === 1'b1);
		end
		chk(12'(cnt), 12'(a[7:0] * 9));
		chk(12'(cnt_g), 12'(a[15:8] * 9));
		chk(12'(cnt_b), 12'(a[23:16] * 9));
		$display("test pwm done");
		close_out();
	end
endmodule
`default_nettype wire
